// ### src/pdc_counter.sv
// Summary of operation
// - Latches follow data while strobe low, hold after
// - Sixteen-bit down counter reloaded from latches
// - Mode select decoded binary, MSB first, 0-7
// - Trigger high loads counter, except hold countdown
// - Trigger low: decrement each edge
// - Mode 0: level high at zero, toggle divider
// - Modes 0, 2: trigger reloads, clears output
// - Mode 1: inverted level, toggle on fall
// - Mode 2: one-clock high pulse at zero
// - Mode 3: inverted one-clock pulse at zero
// - Mode 4: trigger freezes count before zero
// - Hold modes reload only after reaching zero
// - Modes 4, 5: pulse at zero, toggle
// - Mode 6: high from start until zero
// - Mode 6: trigger reloads, output unchanged
// - Mode 6: pulse lasts N-1 clocks
// - Mode 7: pulse, toggle, reload at zero
// - Mode 7 repeats until cleared; only autoreload
// - Mode 7: trigger reloads and clears output
// - Latches zero: idle, no zero events
// - Hold modes ignore trigger loads while counting
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"

module pdc_counter
  import pdc_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`PDC_CNT_W-1:0]  load_value_bus,
  input  wire logic                   write_strobe,
  input  wire logic [2:0]             mode_select,
  input  wire logic                   external_trigger,
  input  wire logic                   master_clear,
  output logic                        zero_out,
  output logic                        div2_out,
  input  wire logic [`PDC_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`PDC_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready
);

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  pdc_state_t st_reg;
  pdc_state_t st_next;
  pdc_pins_t  pin_in;
  pdc_pins_t  agree;
  pdc_mode_t  mode;
  logic       level_m;
  logic       hold_m;
  logic       one_m;
  logic       auto_m;
  logic       inv_m;
  logic       clr;
  logic       trig;
  logic       load_ok;
  logic       count_en;
  logic       zero_ev;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign pin_in = '{we: write_strobe, trig: external_trigger,
                    clr: master_clear, mode: mode_select,
                    data: load_value_bus};

  // Bits where the second and third stages agree
  assign agree = pdc_pins_t'(~(st_reg.s2 ^ st_reg.s3));

  assign mode  = pdc_mode_t'(st_reg.filt.mode);
  assign clr   = st_reg.filt.clr | st_reg.ctrl[`PDC_CTRL_CLR];
  assign trig  = st_reg.filt.trig | st_reg.ctrl[`PDC_CTRL_TRIG];

  always_comb begin
    level_m = 1'b0;
    hold_m  = 1'b0;
    one_m   = 1'b0;
    auto_m  = 1'b0;
    inv_m   = 1'b0;
    case (mode)
      PDC_MODE_LEVEL: begin
        level_m = 1'b1;
      end
      PDC_MODE_LEVEL_INV: begin
        level_m = 1'b1;
        inv_m   = 1'b1;
      end
      PDC_MODE_PULSE: begin
        inv_m   = 1'b0;
      end
      PDC_MODE_PULSE_INV: begin
        inv_m   = 1'b1;
      end
      PDC_MODE_HOLD: begin
        hold_m  = 1'b1;
      end
      PDC_MODE_HOLD_INV: begin
        hold_m  = 1'b1;
        inv_m   = 1'b1;
      end
      PDC_MODE_ONESHOT: begin
        one_m   = 1'b1;
      end
      PDC_MODE_FREQ: begin
        auto_m  = 1'b1;
      end
      default: begin
        level_m = 1'b0;
      end
    endcase
  end

  // Hold modes refuse a load while a count is still running
  assign load_ok  = trig & ~(hold_m & st_reg.armed);
  assign count_en = ~trig & st_reg.armed & (st_reg.cnt != `PDC_CNT_RST);
  assign zero_ev  = count_en & (st_reg.cnt == `PDC_CNT_ONE);

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (araddr)
      `PDC_OFF_CTRL: begin
        rd_mux[1:0] = st_reg.ctrl;
      end
      `PDC_OFF_STATUS: begin
        rd_mux[`PDC_STAT_Q]     = st_reg.q;
        rd_mux[`PDC_STAT_DIV2]  = st_reg.div2;
        rd_mux[`PDC_STAT_ARMED] = st_reg.armed;
        rd_mux[`PDC_STAT_MODE +: 3] = st_reg.filt.mode;
      end
      `PDC_OFF_COUNT: begin
        rd_mux[`PDC_CNT_W-1:0] = st_reg.cnt;
      end
      `PDC_OFF_LATCH: begin
        rd_mux[`PDC_CNT_W-1:0] = st_reg.latch;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;

    // Three-stage pin capture; only stage two reads stage one
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.filt = pdc_pins_t'((agree & st_reg.s3) |
                               (~agree & st_reg.filt));

    // Transparent while the strobe is low, frozen after it rises
    if (!st_reg.filt.we) begin
      st_next.latch = st_reg.filt.data;
    end

    // Pulse modes drop the pulse after one clock
    if (!level_m && !one_m) begin
      st_next.act = 1'b0;
    end

    if (clr) begin
      st_next.cnt   = `PDC_CNT_RST;
      st_next.armed = 1'b0;
      st_next.act   = 1'b0;
      st_next.div2  = 1'b0;
    end else if (load_ok) begin
      st_next.cnt   = st_reg.latch;
      st_next.armed = (st_reg.latch != `PDC_CNT_RST);
      if (!one_m) begin
        st_next.act = 1'b0;
      end
    end else if (count_en) begin
      st_next.cnt = st_reg.cnt - `PDC_CNT_ONE;
      if (one_m) begin
        st_next.act = 1'b1;
      end
      if (zero_ev) begin
        st_next.div2  = ~st_reg.div2;
        st_next.armed = 1'b0;
        if (one_m) begin
          st_next.act = 1'b0;
        end else begin
          st_next.act = 1'b1;
        end
        if (auto_m) begin
          // Only this mode rearms itself without a trigger
          st_next.cnt   = st_reg.latch;
          st_next.armed = (st_reg.latch != `PDC_CNT_RST);
        end
      end
    end

    // Output polarity follows the mode in force
    st_next.q = st_next.act ^ inv_m;

    // Write path: address and data in either order
    if (awvalid && awready) begin
      st_next.aw_got = 1'b1;
      st_next.waddr  = awaddr;
    end
    if (wvalid && wready) begin
      st_next.w_got  = 1'b1;
      st_next.wdata  = wdata;
      st_next.wstrb0 = wstrb[0];
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = `PDC_RESP_OKAY;
      case (st_reg.waddr)
        `PDC_OFF_CTRL: begin
          if (st_reg.wstrb0) begin
            st_next.ctrl = st_reg.wdata[1:0];
          end
        end
        `PDC_OFF_STATUS, `PDC_OFF_COUNT, `PDC_OFF_LATCH: begin
          st_next.bresp = `PDC_RESP_OKAY;
        end
        default: begin
          st_next.bresp = `PDC_RESP_SLVERR;
        end
      endcase
    end

    // Read path
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_mux;
      st_next.rresp  = rd_hit ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign zero_out = st_reg.q;
  assign div2_out = st_reg.div2;
  // Writes stall until the previous response is taken
  assign awready  = ~st_reg.aw_got & ~st_reg.bvalid;
  assign wready   = ~st_reg.w_got & ~st_reg.bvalid;
  assign bvalid   = st_reg.bvalid;
  assign bresp    = st_reg.bresp;
  assign arready  = ~st_reg.rvalid;
  assign rvalid   = st_reg.rvalid;
  assign rdata    = st_reg.rdata;
  assign rresp    = st_reg.rresp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_latch_follow: assert property (
    !st_reg.filt.we |=> st_reg.latch == $past(st_reg.filt.data))
    else $error("latch did not follow data");

  a_latch_hold: assert property (
    st_reg.filt.we |=> $stable(st_reg.latch))
    else $error("latch changed while strobe high");

  a_count_step: assert property (
    (!clr && count_en && st_reg.cnt > `PDC_CNT_ONE)
    |=> st_reg.cnt == $past(st_reg.cnt) - `PDC_CNT_ONE)
    else $error("counter did not decrement");

  a_trig_load: assert property (
    (!clr && trig && !(hold_m && st_reg.armed))
    |=> st_reg.cnt == $past(st_reg.latch))
    else $error("trigger did not load counter");

  a_hold_freeze: assert property (
    (!clr && trig && hold_m && st_reg.armed) |=> $stable(st_reg.cnt))
    else $error("count not frozen in hold mode");

  a_div2_toggle: assert property (
    !clr |=> (st_reg.div2 != $past(st_reg.div2)) == $past(zero_ev))
    else $error("divider toggled without zero");

  a_pulse_width: assert property (
    (!clr && !level_m && !one_m && st_reg.act && $stable(mode))
    |=> !st_reg.act)
    else $error("pulse longer than one clock");

  a_level_stay: assert property (
    (!clr && !trig && level_m && st_reg.act) |=> st_reg.act)
    else $error("level output dropped");

  a_idle_zero: assert property (
    (!clr && trig && !hold_m && st_reg.latch == `PDC_CNT_RST)
    |=> !st_reg.armed && st_reg.cnt == `PDC_CNT_RST)
    else $error("zero load did not idle the counter");

  a_freq_reload: assert property (
    (!clr && auto_m && zero_ev)
    |=> st_reg.cnt == $past(st_reg.latch) && st_reg.act)
    else $error("frequency mode did not reload");

  a_clear_rest: assert property (
    clr |=> st_reg.cnt == `PDC_CNT_RST && !st_reg.act && !st_reg.div2)
    else $error("clear did not rest the block");

  a_clear_level: assert property (
    clr
    |=> st_reg.q == $past(inv_m))
    else $error("clear left output off its rest level");

  a_shot_rise: assert property (
    (!clr && !trig && one_m && st_reg.armed && st_reg.cnt > `PDC_CNT_ONE)
    |=> st_reg.act)
    else $error("one-shot output did not rise");

  a_shot_end: assert property (
    (!clr && !trig && one_m && st_reg.armed && st_reg.cnt == `PDC_CNT_ONE)
    |=> !st_reg.act && st_reg.cnt == `PDC_CNT_RST)
    else $error("one-shot output did not end");

  a_shot_retrig: assert property (
    (!clr && trig && one_m)
    |=> $stable(st_reg.act) && st_reg.cnt == $past(st_reg.latch))
    else $error("retrigger changed one-shot output");

  a_trig_clear: assert property (
    (!clr && trig && !one_m && !hold_m)
    |=> !st_reg.act)
    else $error("trigger did not clear output");

  a_hold_reload: assert property (
    (!clr && trig && hold_m && !st_reg.armed)
    |=> st_reg.cnt == $past(st_reg.latch))
    else $error("hold mode refused reload after zero");

  // Response must stand until the host takes it
  a_bresp_hold: assert property (
    (st_reg.bvalid && !bready)
    |=> st_reg.bvalid && $stable(st_reg.bresp))
    else $error("write response dropped before taken");

endmodule

`default_nettype wire

// ### src/pdc_defs.svh
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define PDC_CNT_W        16
`define PDC_ADDR_W       8
`define PDC_CNT_RST      16'h0000
`define PDC_CNT_ONE      16'h0001

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PDC_OFF_CTRL     8'h00
`define PDC_OFF_STATUS   8'h04
`define PDC_OFF_COUNT    8'h08
`define PDC_OFF_LATCH    8'h0c

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define PDC_CTRL_CLR     0
`define PDC_CTRL_TRIG    1
`define PDC_STAT_Q       0
`define PDC_STAT_DIV2    1
`define PDC_STAT_ARMED   2
`define PDC_STAT_MODE    4
`define PDC_CTRL_RST     2'h0
`define PDC_RESP_OKAY    2'h0
`define PDC_RESP_SLVERR  2'h2

`endif

// ### src/pdc_pkg.sv
`default_nettype none
`include "pdc_defs.svh"

package pdc_pkg;

  // ----------------------------------------
  // Mode selector codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    PDC_MODE_LEVEL     = 3'b000,
    PDC_MODE_LEVEL_INV = 3'b001,
    PDC_MODE_PULSE     = 3'b010,
    PDC_MODE_PULSE_INV = 3'b011,
    PDC_MODE_HOLD      = 3'b100,
    PDC_MODE_HOLD_INV  = 3'b101,
    PDC_MODE_ONESHOT   = 3'b110,
    PDC_MODE_FREQ      = 3'b111
  } pdc_mode_t;

  // ----------------------------------------
  // Pin group and module state
  // ----------------------------------------
  typedef struct packed {
    logic                   we;
    logic                   trig;
    logic                   clr;
    logic [2:0]             mode;
    logic [`PDC_CNT_W-1:0]  data;
  } pdc_pins_t;

  typedef struct packed {
    pdc_pins_t              s1;
    pdc_pins_t              s2;
    pdc_pins_t              s3;
    pdc_pins_t              filt;
    logic [`PDC_CNT_W-1:0]  latch;
    logic [`PDC_CNT_W-1:0]  cnt;
    logic                   armed;
    logic                   act;
    logic                   q;
    logic                   div2;
    logic [1:0]             ctrl;
    logic                   aw_got;
    logic                   w_got;
    logic [`PDC_ADDR_W-1:0] waddr;
    logic [31:0]            wdata;
    logic                   wstrb0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } pdc_state_t;

endpackage

`default_nettype wire

// ### sim/pdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"

module pdc_host_model (
  input  wire logic                  aclk,
  output logic [`PDC_CNT_W-1:0]      load_value_bus,
  output logic                       write_strobe,
  output logic [2:0]                 mode_select,
  output logic                       external_trigger,
  output logic                       master_clear
);
  initial begin
    load_value_bus = 16'h0000;
    write_strobe = 1'b1;
    mode_select = 3'h0;
    external_trigger = 1'b0;
    master_clear = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ----
  // Pin sequences, each held past the input filter
  // ----
  task automatic trig(input logic v);
    external_trigger <= v;
    tick(8);
  endtask

  task automatic clear();
    master_clear <= 1'b1;
    tick(6);
    master_clear <= 1'b0;
    tick(6);
  endtask

  // Bus scrambled after the strobe so a late capture shows
  task automatic load(input logic [`PDC_CNT_W-1:0] n);
    write_strobe <= 1'b0;
    load_value_bus <= n;
    tick(6);
    write_strobe <= 1'b1;
    tick(2);
    load_value_bus <= ~n;
    tick(4);
  endtask

  // One-shot never gets a count of one
  task automatic start(input logic [2:0] m, input logic [15:0] n);
    mode_select <= m;
    external_trigger <= 1'b0;
    clear();
    load((m == 3'h6 && n == 16'h0001) ? 16'h0002 : n);
    trig(1'b1);
    external_trigger <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ### sim/pdc_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.svh"

module pdc_counter_bench;
  import pdc_pkg::*;

  typedef struct packed {
    logic        q;
    logic        q1;
    logic        d;
    logic [15:0] len;
  } pdc_note_t;

  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic [`PDC_CNT_W-1:0]  load_value_bus;
  logic                   write_strobe, external_trigger, master_clear;
  logic [2:0]             mode_select;
  logic                   zero_out, div2_out;
  logic [7:0]             awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]            wdata = 32'h0, rdata;
  logic [3:0]             wstrb = 4'hf;
  logic                   awvalid = 0, wvalid = 0, bready = 0;
  logic                   arvalid = 0, rready = 0;
  logic                   awready, wready, bvalid, arready, rvalid;
  logic [1:0]             bresp, rresp;
  logic                   pz, pd, want1, quiet = 1'b1;
  int                     run, n_errors, comparisons;
  pdc_note_t              notes[$];
  pdc_note_t              cur;

  always #5 aclk = ~aclk;

  pdc_host_model u_host (.aclk(aclk), .load_value_bus(load_value_bus),
    .write_strobe(write_strobe), .mode_select(mode_select),
    .external_trigger(external_trigger), .master_clear(master_clear));

  pdc_counter u_dut (.aclk(aclk), .aresetn(aresetn),
    .load_value_bus(load_value_bus), .write_strobe(write_strobe),
    .mode_select(mode_select), .external_trigger(external_trigger),
    .master_clear(master_clear), .zero_out(zero_out), .div2_out(div2_out),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  // ----
  // Compare, bus and verdict tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin
        awvalid <= 0;
        pa = 0;
      end
      if (pw && wready) begin
        wvalid <= 0;
        pw = 0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 0;
    r = bresp;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask

  task automatic drain(input int lim);
    int i;
    i = 0;
    while (notes.size() != 0 && i < lim) begin
      @(posedge aclk);
      i++;
    end
    chk("events left", 0, notes.size());
    repeat (2) @(posedge aclk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic pdc_note_t mk(input int m, input logic d,
                                   input logic [15:0] len);
    logic      r;
    pdc_note_t t;
    r = (m == 1 || m == 3 || m == 5);
    t.q = (m == 6) ? 1'b0 : !r;
    t.q1 = (m < 2) ? !r : ((m == 6) ? 1'b0 : r);
    t.d = d;
    t.len = len;
    return t;
  endfunction

  // ----
  // Event watcher: each divider toggle takes the oldest note
  // ----
  always @(negedge aclk) begin
    if (!quiet) begin
      if (want1)
        chk("zero_out next", cur.q1, zero_out);
      want1 = 0;
      if (div2_out !== pd) begin
        if (notes.size() == 0)
          chk("stray event", 0, 1);
        else begin
          cur = notes.pop_front();
          chk("zero_out", cur.q, zero_out);
          chk("div2_out", cur.d, div2_out);
          if (cur.len != 0)
            chk("width", cur.len, run);
          want1 = 1;
        end
      end
    end
    run = (zero_out !== pz || div2_out !== pd) ? 1 : run + 1;
    pz = zero_out;
    pd = div2_out;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    chk("timeout", 0, 1);
    end_sim();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    logic [31:0] v;
    logic [1:0]  rs;
    logic [15:0] n;
    v = $urandom(32'h200e);
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`PDC_OFF_CTRL, v, rs);
    chk("ctrl reset", 0, v);
    rd(8'h10, v, rs);
    chk("unmapped rd", `PDC_RESP_SLVERR, rs);
    wr(8'h20, 32'h3, rs);
    chk("unmapped wr", `PDC_RESP_SLVERR, rs);
    wstrb <= 4'h0;
    wr(`PDC_OFF_CTRL, 32'h3, rs);
    wstrb <= 4'hf;
    rd(`PDC_OFF_CTRL, v, rs);
    chk("ctrl strobe", 0, v);
    for (int m = 0; m < 8; m++) begin
      n = 16'(3 + $urandom % 16);
      quiet = 1;
      u_host.start(3'(m), n);
      quiet = 0;
      notes.push_back(mk(m, 1'b1, (m == 6) ? n - 16'h1 : 16'h0));
      if (m == 7) begin
        notes.push_back(mk(m, 1'b0, n - 16'h1));
        notes.push_back(mk(m, 1'b1, n - 16'h1));
      end
      rd(`PDC_OFF_STATUS, v, rs);
      chk("mode", m, v[6:4]);
      rd(`PDC_OFF_LATCH, v, rs);
      chk("latch", n, v);
      drain(200);
      if (m < 2) begin
        u_host.trig(1'b1);
        chk("zero_out rest", m, zero_out);
      end
    end
    quiet = 1;
    u_host.clear();
    quiet = 0;
    chk("clear q", 0, zero_out);
    chk("clear div2", 0, div2_out);
    repeat (60) @(posedge aclk);
    quiet = 1;
    u_host.start(3'h4, 16'h0028);
    quiet = 0;
    notes.push_back(mk(4, 1'b1, 16'h0));
    repeat (15) @(posedge aclk);
    u_host.trig(1'b1);
    u_host.load(16'h0fff);
    repeat (30) @(posedge aclk);
    chk("frozen", 1, notes.size());
    u_host.trig(1'b0);
    drain(60);
    quiet = 1;
    u_host.start(3'h2, 16'h0000);
    quiet = 0;
    repeat (100) @(posedge aclk);
    rd(`PDC_OFF_STATUS, v, rs);
    chk("armed", 0, v[`PDC_STAT_ARMED]);
    rd(`PDC_OFF_COUNT, v, rs);
    chk("count idle", 0, v);
    u_host.load(16'h0005);
    notes.push_back(mk(2, 1'b1, 16'h0));
    wr(`PDC_OFF_CTRL, 32'h2, rs);
    chk("ctrl resp", `PDC_RESP_OKAY, rs);
    wr(`PDC_OFF_CTRL, 32'h0, rs);
    drain(60);
    quiet = 1;
    wr(`PDC_OFF_CTRL, 32'h1, rs);
    rd(`PDC_OFF_STATUS, v, rs);
    chk("soft clear", 0, v[`PDC_STAT_DIV2]);
    wr(`PDC_OFF_CTRL, 32'h0, rs);
    end_sim();
  end
endmodule

`default_nettype wire
